// File: core/tpg_color.sv
// colour bar / uniform colour generator with black border
`timescale 1ns/1ps
module tpg_color
	import tpg_pkg::*;
#(
	parameter int              BPS         = DEF_BPS,
	parameter tpg_space_type   COLOR_SPACE = TPG_RGB,
	parameter tpg_format_type  FORMAT      = FMT_444,
	parameter tpg_pattern_type PATTERN     = PAT_BARS
)(
	input  wire logic ref_clk,
	input  wire logic resetn,
	tpg_pix_if.color  pix
);
	localparam logic [15:0] BORDER_H = (FORMAT != FMT_444) ? 16'h2 : 16'h1;
	localparam logic [15:0] BORDER_V = (FORMAT == FMT_420) ? 16'h2 : 16'h1;

	logic [15:0] pos_reg;
	logic [15:0] pos_next;
	logic [2:0]  idx_reg;
	logic [2:0]  idx_next;
	logic [15:0] bar_raw;
	logic [15:0] bar_w;
	logic        in_h;
	logic        in_v;
	logic [23:0] rgb8;

	// truncation or zero promotion of an 8-bit table value
	function automatic logic [BPS-1:0] scale(input logic [7:0] v);
		logic [TABLE_BITS+MAX_BPS-1:0] t;
		t = {v, {MAX_BPS{1'b0}}};
		return t[TABLE_BITS+MAX_BPS-1 -: BPS];
	endfunction

	// horizontal border widens to two under subsampling, vertical border under 4:2:0 only
	assign in_h = (pix.x >= BORDER_H) && (pix.x < pix.width - BORDER_H);
	assign in_v = (pix.y >= BORDER_V) && (pix.y < pix.height - BORDER_V);
	assign bar_raw = (pix.width - (BORDER_H << 1)) >> 3;
	assign bar_w = (FORMAT != FMT_444) ? {bar_raw[15:1], 1'b0} : bar_raw;

	always_comb
	begin
		pos_next = pos_reg;
		idx_next = idx_reg;
		if (pix.line_start)
		begin
			pos_next = 16'h0;
			idx_next = 3'h0;
		end
		else if (pix.pix_adv && in_h)
		begin
			// last bar absorbs the remainder
			if (idx_reg != BAR_LAST && pos_reg == bar_w - 16'h1)
			begin
				pos_next = 16'h0;
				idx_next = idx_reg + 3'h1;
			end
			else
				pos_next = pos_reg + 16'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pos_reg <= 16'h0;
			idx_reg <= 3'h0;
		end
		else
		begin
			pos_reg <= pos_next;
			idx_reg <= idx_next;
		end
	end

	always_comb
	begin
		if (!(in_h && in_v))
			rgb8 = (COLOR_SPACE == TPG_RGB) ? BAR_RGB[BAR_LAST]
				: BAR_YCC[BAR_LAST];
		else if (PATTERN == PAT_UNIFORM)
			rgb8 = {pix.uni0, pix.uni1, pix.uni2};
		else
			rgb8 = (COLOR_SPACE == TPG_RGB) ? BAR_RGB[idx_reg]
				: BAR_YCC[idx_reg];
	end

	assign pix.c0 = scale(rgb8[23:16]);
	assign pix.c1 = scale(rgb8[15:8]);
	assign pix.c2 = scale(rgb8[7:0]);
endmodule // tpg_color

// File: core/tpg_pix_if.sv
// position-to-colour link between the sequencer and the colour generator
`timescale 1ns/1ps
interface tpg_pix_if #(parameter int BPS = 8);
	logic [15:0]    x;
	logic [15:0]    y;
	logic [15:0]    width;
	logic [15:0]    height;
	logic           line_start;
	logic           pix_adv;
	logic [7:0]     uni0;
	logic [7:0]     uni1;
	logic [7:0]     uni2;
	logic [BPS-1:0] c0;
	logic [BPS-1:0] c1;
	logic [BPS-1:0] c2;
	modport gen (output x, y, width, height, line_start, pix_adv,
		uni0, uni1, uni2, input c0, c1, c2);
	modport color (input x, y, width, height, line_start, pix_adv,
		uni0, uni1, uni2, output c0, c1, c2);
endinterface

// File: core/tpg_pkg.sv
// constants, register map and types of the video test pattern source
package tpg_pkg;
	localparam int          REG_W           = 16;
	localparam int          ADDR_W          = 3;
	localparam logic [2:0]  ADDR_RUN_CTRL   = 3'h0;
	localparam logic [2:0]  ADDR_RUN_STATUS = 3'h1;
	localparam logic [2:0]  ADDR_WIDTH      = 3'h2;
	localparam logic [2:0]  ADDR_HEIGHT     = 3'h3;
	localparam logic [2:0]  ADDR_UNI_FIRST  = 3'h4;
	localparam logic [2:0]  ADDR_UNI_SECOND = 3'h5;
	localparam logic [2:0]  ADDR_UNI_THIRD  = 3'h6;
	localparam int          GO_BIT          = 0;
	localparam int          BUSY_BIT        = 0;
	localparam int          DEF_MAX_WIDTH   = 640;
	localparam int          DEF_MAX_HEIGHT  = 480;
	localparam int          MIN_SIZE        = 32;
	localparam int          LIMIT_SIZE      = 2600;
	localparam int          DEF_BPS         = 8;
	localparam int          MIN_BPS         = 4;
	localparam int          MAX_BPS         = 20;
	localparam int          TABLE_BITS      = 8;
	localparam logic [7:0]  UNIFORM_DEFAULT = 8'h80;
	localparam logic [3:0]  PKT_VIDEO       = 4'h0;
	localparam logic [3:0]  PKT_CTRL        = 4'hf;
	localparam logic [3:0]  NIB_LAST        = 4'h8;
	localparam logic [3:0]  ILACE_PROG      = 4'h0;
	localparam logic [2:0]  BAR_LAST        = 3'h7;
	localparam logic [1:0]  ILACE_FIELD     = 2'h2;
	// {first, second, third} component, 8 bits each, 75% bars
	localparam logic [23:0] BAR_RGB [0:7] = '{
		24'hb4b4b4, 24'hb4b410, 24'h10b4b4, 24'h10b410,
		24'hb410b4, 24'hb41010, 24'h1010b4, 24'h101010};
	localparam logic [23:0] BAR_YCC [0:7] = '{
		24'hb48080, 24'ha22c8e, 24'h839c2c, 24'h70483a,
		24'h54b8c6, 24'h4164d4, 24'h23d472, 24'h108080};
	typedef enum logic {TPG_RGB, TPG_YCBCR} tpg_space_type;
	typedef enum logic [1:0] {FMT_444, FMT_422, FMT_420} tpg_format_type;
	typedef enum logic [1:0] {SCAN_PROG, SCAN_EVEN_FIRST, SCAN_ODD_FIRST}
		tpg_scan_type;
	typedef enum logic {PAT_BARS, PAT_UNIFORM} tpg_pattern_type;
	typedef enum {
		ST_IDLE, ST_LATCH, ST_CTRL_HDR, ST_CTRL_BODY,
		ST_DATA_HDR, ST_PIXELS, ST_LINE_END, ST_FIELD_END
	} tpg_state_type;
endpackage

// File: core/tpg_top.sv
// video test pattern source: control slave, packet sequencer, stream out
`timescale 1ns/1ps
module tpg_top
	import tpg_pkg::*;
#(
	parameter bit              RUNTIME_CTRL = 1'b0,
	parameter int              MAX_WIDTH    = DEF_MAX_WIDTH,
	parameter int              MAX_HEIGHT   = DEF_MAX_HEIGHT,
	parameter int              BPS          = DEF_BPS,
	parameter tpg_space_type   COLOR_SPACE  = TPG_RGB,
	parameter tpg_format_type  FORMAT       = FMT_444,
	parameter bit              PARALLEL     = 1'b0,
	parameter tpg_scan_type    SCAN         = SCAN_PROG,
	parameter tpg_pattern_type PATTERN      = PAT_BARS,
	parameter logic [7:0]      UNIFORM_0    = UNIFORM_DEFAULT,
	parameter logic [7:0]      UNIFORM_1    = UNIFORM_DEFAULT,
	parameter logic [7:0]      UNIFORM_2    = UNIFORM_DEFAULT
)(
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] ctrl_slave_addr,
	input  wire logic              ctrl_slave_select,
	input  wire logic              ctrl_slave_wr,
	input  wire logic [REG_W-1:0]  ctrl_slave_wdata,
	output logic      [REG_W-1:0]  ctrl_slave_rdata,
	output logic      [3*BPS-1:0]  dout_data,
	output logic                   dout_valid,
	input  wire logic              dout_ready,
	output logic                   dout_startofpacket,
	output logic                   dout_endofpacket
);
	localparam int DW = 3 * BPS;
	localparam logic [1:0] SYM_LAST = PARALLEL ? 2'd0
		: ((FORMAT == FMT_444) ? 2'd2 : 2'd1);
	localparam bit ILACE = (SCAN != SCAN_PROG);
	localparam bit UNI_REGS = RUNTIME_CTRL && (PATTERN == PAT_UNIFORM);
	localparam logic [15:0] MAXW = 16'(MAX_WIDTH);
	localparam logic [15:0] MAXH = 16'(MAX_HEIGHT);

	initial
	begin
		if (MAX_WIDTH < MIN_SIZE || MAX_WIDTH > LIMIT_SIZE ||
			MAX_HEIGHT < MIN_SIZE || MAX_HEIGHT > LIMIT_SIZE ||
			BPS < MIN_BPS || BPS > MAX_BPS)
			$error("tpg_top: parameter out of range");
	end

	logic              go_reg, go_next;
	logic [15:0]       width_reg, width_next;
	logic [15:0]       height_reg, height_next;
	logic [7:0]        uni0_reg, uni0_next;
	logic [7:0]        uni1_reg, uni1_next;
	logic [7:0]        uni2_reg, uni2_next;
	logic [REG_W-1:0]  rdata_reg, rdata_next;
	tpg_state_type     state_reg, state_next;
	logic [15:0]       lat_w_reg, lat_w_next;
	logic [15:0]       lat_h_reg, lat_h_next;
	logic [7:0]        lu0_reg, lu0_next;
	logic [7:0]        lu1_reg, lu1_next;
	logic [7:0]        lu2_reg, lu2_next;
	logic [15:0]       x_reg, x_next;
	logic [15:0]       y_reg, y_next;
	logic [1:0]        sym_reg, sym_next;
	logic [3:0]        nib_reg, nib_next;
	logic              second_reg, second_next;
	logic              odd_reg, odd_next;
	logic              valid_reg, valid_next;
	logic [DW-1:0]     data_reg, data_next;
	logic              sop_reg, sop_next;
	logic              eop_reg, eop_next;
	logic              load;
	logic [15:0]       field_h;
	logic [15:0]       frame_y;
	logic [BPS-1:0]    chroma;
	logic [DW-1:0]     sample;

	tpg_pix_if #(.BPS(BPS)) pix ();

	tpg_color #(
		.BPS         (BPS),
		.COLOR_SPACE (COLOR_SPACE),
		.FORMAT      (FORMAT),
		.PATTERN     (PATTERN)
	) u_color (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.pix     (pix)
	);

	function automatic logic [3:0] ctrl_nibble(input logic [3:0] n,
		input logic [15:0] w, input logic [15:0] h, input logic [3:0] il);
		case (n)
			4'h0: return w[15:12];
			4'h1: return w[11:8];
			4'h2: return w[7:4];
			4'h3: return w[3:0];
			4'h4: return h[15:12];
			4'h5: return h[11:8];
			4'h6: return h[7:4];
			4'h7: return h[3:0];
			default: return il;
		endcase
	endfunction

	// control slave
	always_comb
	begin
		go_next = go_reg;
		width_next = width_reg;
		height_next = height_reg;
		uni0_next = uni0_reg;
		uni1_next = uni1_reg;
		uni2_next = uni2_reg;
		rdata_next = rdata_reg;
		if (RUNTIME_CTRL && ctrl_slave_select)
		begin
			if (ctrl_slave_wr)
			begin
				case (ctrl_slave_addr)
					ADDR_RUN_CTRL: go_next = ctrl_slave_wdata[GO_BIT];
					ADDR_WIDTH:    width_next = ctrl_slave_wdata;
					ADDR_HEIGHT:   height_next = ctrl_slave_wdata;
					// uniform words gated by build options
					ADDR_UNI_FIRST:
						if (UNI_REGS) uni0_next = ctrl_slave_wdata[7:0];
					ADDR_UNI_SECOND:
						if (UNI_REGS) uni1_next = ctrl_slave_wdata[7:0];
					ADDR_UNI_THIRD:
						if (UNI_REGS) uni2_next = ctrl_slave_wdata[7:0];
					default: ;
				endcase
			end
			rdata_next = '0;
			case (ctrl_slave_addr)
				ADDR_RUN_CTRL:   rdata_next[GO_BIT] = go_reg;
				// busy from first copy to end of frame
				ADDR_RUN_STATUS: rdata_next[BUSY_BIT] = (state_reg != ST_IDLE);
				ADDR_WIDTH:      rdata_next = width_reg;
				ADDR_HEIGHT:     rdata_next = height_reg;
				ADDR_UNI_FIRST:  if (UNI_REGS) rdata_next[7:0] = uni0_reg;
				ADDR_UNI_SECOND: if (UNI_REGS) rdata_next[7:0] = uni1_reg;
				ADDR_UNI_THIRD:  if (UNI_REGS) rdata_next[7:0] = uni2_reg;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			go_reg <= 1'b0;
			width_reg <= MAXW;
			height_reg <= MAXH;
			uni0_reg <= UNIFORM_0;
			uni1_reg <= UNIFORM_1;
			uni2_reg <= UNIFORM_2;
			rdata_reg <= '0;
		end
		else
		begin
			go_reg <= go_next;
			width_reg <= width_next;
			height_reg <= height_next;
			uni0_reg <= uni0_next;
			uni1_reg <= uni1_next;
			uni2_reg <= uni2_next;
			rdata_reg <= rdata_next;
		end
	end

	// a beat is loaded when the output is empty or being taken
	assign load = !valid_reg || dout_ready;
	// field height is half the progressive height when interlaced, equal to it otherwise
	assign field_h = ILACE ? {1'b0, lat_h_reg[15:1]} : lat_h_reg;
	assign frame_y = ILACE ? {y_reg[14:0], odd_reg} : y_reg;
	assign chroma = (FORMAT == FMT_422) ? (x_reg[0] ? pix.c2 : pix.c1)
		: (frame_y[0] ? pix.c2 : pix.c1);

	assign pix.x = x_reg;
	assign pix.y = frame_y;
	assign pix.width = lat_w_reg;
	assign pix.height = lat_h_reg;
	assign pix.uni0 = lu0_reg;
	assign pix.uni1 = lu1_reg;
	assign pix.uni2 = lu2_reg;
	assign pix.line_start = (state_reg == ST_DATA_HDR) ||
		(state_reg == ST_LINE_END);
	assign pix.pix_adv = (state_reg == ST_PIXELS) && load &&
		(sym_reg == SYM_LAST);

	always_comb
	begin
		sample = '0;
		if (PARALLEL)
			sample = (FORMAT == FMT_444) ? {pix.c2, pix.c1, pix.c0}
				: {{BPS{1'b0}}, chroma, pix.c0};
		else if (sym_reg == 2'd0)
			sample[BPS-1:0] = pix.c0;
		else if (FORMAT != FMT_444)
			sample[BPS-1:0] = chroma;
		else if (sym_reg == 2'd1)
			sample[BPS-1:0] = pix.c1;
		else
			sample[BPS-1:0] = pix.c2;
	end

	// frame sequencer and stream output
	always_comb
	begin
		state_next = state_reg;
		lat_w_next = lat_w_reg;
		lat_h_next = lat_h_reg;
		lu0_next = lu0_reg;
		lu1_next = lu1_reg;
		lu2_next = lu2_reg;
		x_next = x_reg;
		y_next = y_reg;
		sym_next = sym_reg;
		nib_next = nib_reg;
		second_next = second_reg;
		odd_next = odd_reg;
		valid_next = dout_ready ? 1'b0 : valid_reg;
		data_next = data_reg;
		// packet marks fall together with valid
		sop_next = dout_ready ? 1'b0 : sop_reg;
		eop_next = dout_ready ? 1'b0 : eop_reg;
		case (state_reg)
			ST_IDLE:
				// no new copy while run bit is clear, unless built without runtime control
				if (go_reg || !RUNTIME_CTRL)
					state_next = ST_LATCH;
			ST_LATCH:
			begin
				// private copy of the settings for one frame
				lat_w_next = RUNTIME_CTRL ? width_reg : MAXW;
				lat_h_next = RUNTIME_CTRL ? height_reg : MAXH;
				lu0_next = UNI_REGS ? uni0_reg : UNIFORM_0;
				lu1_next = UNI_REGS ? uni1_reg : UNIFORM_1;
				lu2_next = UNI_REGS ? uni2_reg : UNIFORM_2;
				second_next = 1'b0;
				odd_next = (SCAN == SCAN_ODD_FIRST);
				state_next = ST_CTRL_HDR;
			end
			ST_CTRL_HDR:
				// control packet ahead of image packet
				if (load)
				begin
					valid_next = 1'b1;
					data_next = {{(DW-4){1'b0}}, PKT_CTRL};
					sop_next = 1'b1;
					eop_next = 1'b0;
					nib_next = 4'h0;
					state_next = ST_CTRL_BODY;
				end
			ST_CTRL_BODY:
				if (load)
				begin
					valid_next = 1'b1;
					data_next = {{(DW-4){1'b0}}, ctrl_nibble(nib_reg,
						lat_w_reg, field_h,
						ILACE ? {ILACE_FIELD, odd_reg, 1'b0} : ILACE_PROG)};
					sop_next = 1'b0;
					eop_next = (nib_reg == NIB_LAST);
					nib_next = nib_reg + 4'h1;
					if (nib_reg == NIB_LAST)
						state_next = ST_DATA_HDR;
				end
			ST_DATA_HDR:
				if (load)
				begin
					valid_next = 1'b1;
					data_next = {{(DW-4){1'b0}}, PKT_VIDEO};
					sop_next = 1'b1;
					eop_next = 1'b0;
					x_next = 16'h0;
					y_next = 16'h0;
					sym_next = 2'd0;
					state_next = ST_PIXELS;
				end
			ST_PIXELS:
				// one sample per cycle unless stalled
				if (load)
				begin
					valid_next = 1'b1;
					data_next = sample;
					sop_next = 1'b0;
					// last sample of the field ends the packet
					eop_next = (sym_reg == SYM_LAST) &&
						(x_reg == lat_w_reg - 16'h1) &&
						(y_reg == field_h - 16'h1);
					sym_next = sym_reg + 2'd1;
					if (sym_reg == SYM_LAST)
					begin
						sym_next = 2'd0;
						x_next = x_reg + 16'h1;
						if (x_reg == lat_w_reg - 16'h1)
						begin
							x_next = 16'h0;
							if (y_reg == field_h - 16'h1)
								state_next = ST_FIELD_END;
							else
							begin
								y_next = y_reg + 16'h1;
								state_next = ST_LINE_END;
							end
						end
					end
				end
			ST_LINE_END:
				state_next = ST_PIXELS;
			ST_FIELD_END:
				// second field reuses the copy, new control packet
				if (ILACE && !second_reg)
				begin
					second_next = 1'b1;
					odd_next = !odd_reg;
					state_next = ST_CTRL_HDR;
				end
				else
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= ST_IDLE;
			lat_w_reg <= MAXW;
			lat_h_reg <= MAXH;
			lu0_reg <= UNIFORM_0;
			lu1_reg <= UNIFORM_1;
			lu2_reg <= UNIFORM_2;
			x_reg <= 16'h0;
			y_reg <= 16'h0;
			sym_reg <= 2'd0;
			nib_reg <= 4'h0;
			second_reg <= 1'b0;
			odd_reg <= 1'b0;
			valid_reg <= 1'b0;
			data_reg <= '0;
			sop_reg <= 1'b0;
			eop_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			lat_w_reg <= lat_w_next;
			lat_h_reg <= lat_h_next;
			lu0_reg <= lu0_next;
			lu1_reg <= lu1_next;
			lu2_reg <= lu2_next;
			x_reg <= x_next;
			y_reg <= y_next;
			sym_reg <= sym_next;
			nib_reg <= nib_next;
			second_reg <= second_next;
			odd_reg <= odd_next;
			valid_reg <= valid_next;
			data_reg <= data_next;
			sop_reg <= sop_next;
			eop_reg <= eop_next;
		end
	end

	assign ctrl_slave_rdata = rdata_reg;
	assign dout_data = data_reg;
	assign dout_valid = valid_reg;
	assign dout_startofpacket = sop_reg;
	assign dout_endofpacket = eop_reg;
endmodule // tpg_top

// File: testbench/tpg_sink.sv
// downstream receiver: ready at once, or with pseudo-random stalls
`timescale 1ns/1ps
module tpg_sink (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic slow,
	output logic      dout_ready
);
	logic [7:0] lfsr_reg;

	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lfsr_reg   <= 8'h5a;
			dout_ready <= 1'b0;
		end
		else
		begin
			lfsr_reg   <= {lfsr_reg[6:0], ^(lfsr_reg & 8'hb8)};
			dout_ready <= !slow || lfsr_reg[0];
		end
	end
endmodule // tpg_sink

// File: testbench/tpg_top_sva.sv
// concurrent checks on the ports of the test pattern source
`timescale 1ns/1ps
module tpg_top_sva
	import tpg_pkg::*;
#(
	parameter int BPS = DEF_BPS
)(
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] ctrl_slave_addr,
	input  wire logic              ctrl_slave_select,
	input  wire logic              ctrl_slave_wr,
	input  wire logic [REG_W-1:0]  ctrl_slave_wdata,
	input  wire logic [REG_W-1:0]  ctrl_slave_rdata,
	input  wire logic [3*BPS-1:0]  dout_data,
	input  wire logic              dout_valid,
	input  wire logic              dout_ready,
	input  wire logic              dout_startofpacket,
	input  wire logic              dout_endofpacket
);
	logic in_pkt_reg;
	logic in_pkt_next;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence acc(logic [2:0] a, bit w);
		ctrl_slave_select && ctrl_slave_wr == w && ctrl_slave_addr == a;
	endsequence

	// tracks whether a packet has started and not yet ended
	always_comb
	begin
		in_pkt_next = in_pkt_reg;
		if (dout_valid && dout_ready)
			in_pkt_next = !dout_endofpacket;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			in_pkt_reg <= 1'b0;
		else
			in_pkt_reg <= in_pkt_next;
	end

	stall_hold_a: assert property (dout_valid && !dout_ready |=>
		dout_valid && $stable(dout_data) && $stable(dout_endofpacket)
		&& $stable(dout_startofpacket))
		else $error("stream beat changed under backpressure");
	marks_qualified_a: assert property (
		dout_startofpacket || dout_endofpacket |-> dout_valid)
		else $error("packet mark without valid");
	pkt_framing_a: assert property (
		dout_valid |-> dout_startofpacket == !in_pkt_reg)
		else $error("start of packet out of place");
	rdata_hold_a: assert property (
		!ctrl_slave_select |=> $stable(ctrl_slave_rdata))
		else $error("read data moved without select");
	unmapped_read_a: assert property (acc(3'h7, 0) |=>
		ctrl_slave_rdata == 16'h0000)
		else $error("unmapped word read not zero");
	go_bits_a: assert property (acc(ADDR_RUN_CTRL, 0) |=>
		(ctrl_slave_rdata & 16'hfffe) == 16'h0000)
		else $error("unused run control bits not zero");
	status_busy_a: assert property (dout_valid && ctrl_slave_select
		&& !ctrl_slave_wr && ctrl_slave_addr == ADDR_RUN_STATUS
		|=> ctrl_slave_rdata == 16'h0001)
		else $error("status not busy while streaming");
	width_write_a: assert property (
		acc(ADDR_WIDTH, 1) ##1 acc(ADDR_WIDTH, 0)
		|=> ctrl_slave_rdata == $past(ctrl_slave_wdata, 2))
		else $error("width word not stored");
	height_write_a: assert property (
		acc(ADDR_HEIGHT, 1) ##1 acc(ADDR_HEIGHT, 0)
		|=> ctrl_slave_rdata == $past(ctrl_slave_wdata, 2))
		else $error("height word not stored");
	uniform_write_a: assert property (
		acc(ADDR_UNI_FIRST, 1) ##1 acc(ADDR_UNI_FIRST, 0)
		|=> ctrl_slave_rdata == ($past(ctrl_slave_wdata, 2) & 16'h00ff))
		else $error("uniform word not stored");

	cover property (dout_valid && dout_ready && dout_endofpacket);
	cover property (dout_valid && !dout_ready);
	cover property (dout_valid and acc(ADDR_RUN_STATUS, 0));
endmodule // tpg_top_sva

bind tpg_top tpg_top_sva #(.BPS(BPS)) u_tpg_sva (
	.ref_clk            (ref_clk),
	.resetn             (resetn),
	.ctrl_slave_addr    (ctrl_slave_addr),
	.ctrl_slave_select  (ctrl_slave_select),
	.ctrl_slave_wr      (ctrl_slave_wr),
	.ctrl_slave_wdata   (ctrl_slave_wdata),
	.ctrl_slave_rdata   (ctrl_slave_rdata),
	.dout_data          (dout_data),
	.dout_valid         (dout_valid),
	.dout_ready         (dout_ready),
	.dout_startofpacket (dout_startofpacket),
	.dout_endofpacket   (dout_endofpacket)
);

// File: testbench/video_test_pattern_source_tb.sv
// self-checking bench of the test pattern source
`timescale 1ns/1ps
module video_test_pattern_source_tb;
	import tpg_pkg::*;
	localparam int MW   = 40;
	localparam int MH   = 34;
	localparam int CEIL = 60000;
	logic              ref_clk = 1'b0;
	logic              resetn  = 1'b0;
	logic [ADDR_W-1:0] addr    = '0;
	logic              sel     = 1'b0;
	logic              wr      = 1'b0;
	logic [REG_W-1:0]  wdata   = '0;
	logic              slow    = 1'b0;
	logic [REG_W-1:0]  rdata;
	logic [23:0]       data;
	logic              valid;
	logic              ready;
	logic              sop;
	logic              eop;
	logic [REG_W-1:0]  rdata2;
	logic [23:0]       data2;
	logic              valid2;
	logic              sop2;
	logic              eop2;
	logic [15:0]       seed    = 16'd54431;
	logic [7:0]        u [0:2];
	logic [26:0]       exp_q [$];
	int                mismatches = 0;
	int                checked    = 0;
	int                cycles     = 0;
	int                w;
	int                h;
	int                len;
	int                beat2      = 0;

	always #12.5 ref_clk = ~ref_clk;

	tpg_top #(.RUNTIME_CTRL(1'b1), .MAX_WIDTH(MW), .MAX_HEIGHT(MH),
		.PARALLEL(1'b1), .PATTERN(PAT_UNIFORM)) dut (
		.ref_clk            (ref_clk),
		.resetn             (resetn),
		.ctrl_slave_addr    (addr),
		.ctrl_slave_select  (sel),
		.ctrl_slave_wr      (wr),
		.ctrl_slave_wdata   (wdata),
		.ctrl_slave_rdata   (rdata),
		.dout_data          (data),
		.dout_valid         (valid),
		.dout_ready         (ready),
		.dout_startofpacket (sop),
		.dout_endofpacket   (eop)
	);

	tpg_sink u_sink (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.slow       (slow),
		.dout_ready (ready)
	);

	// fixed 32x32 sequential colour bars; no slave in this build
	tpg_top #(.MAX_WIDTH(32), .MAX_HEIGHT(32)) dut_bars (
		.ref_clk            (ref_clk),
		.resetn             (resetn),
		.ctrl_slave_addr    (addr),
		.ctrl_slave_select  (1'b0),
		.ctrl_slave_wr      (wr),
		.ctrl_slave_wdata   (wdata),
		.ctrl_slave_rdata   (rdata2),
		.dout_data          (data2),
		.dout_valid         (valid2),
		.dout_ready         (ready),
		.dout_startofpacket (sop2),
		.dout_endofpacket   (eop2)
	);

	function automatic logic [15:0] rnd(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// beat b of the 32x32 bar frame: header, 9 nibbles, header, 3 per pixel
	function automatic logic [26:0] bar_beat(input int b);
		int          p;
		int          x;
		int          y;
		logic [23:0] c;
		p = b - 11;
		x = (p / 3) % 32;
		y = p / 96;
		if (b == 0)
			return {3'b110, 24'h00000f};
		if (b <= 9)
			return {2'b10, b == 9, 20'h0, (b == 3 || b == 7) ? 4'h2 : 4'h0};
		if (b == 10)
			return {3'b110, 24'h0};
		c = BAR_RGB[((x - 1) / 3 > 7) ? 7 : (x - 1) / 3];
		if (x == 0 || y == 0 || x == 31 || y == 31)
			c = 24'h101010;
		return {2'b00, b == 3082, 16'h0, c[23 - 8 * (p % 3) -: 8]};
	endfunction

	task automatic final_report();
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp_reg(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_beat(input logic [26:0] e, input logic [26:0] g);
		checked++;
		if (e[26])
			g = {1'b1, g[25:24], 20'h0, g[3:0]};
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED beat expected %h seen %h", e, g);
		end
	endtask

	// optional write cycle, then a read cycle of the same word
	task automatic xfer(input logic [2:0] a, input logic [15:0] d,
		input bit do_wr, input logic [15:0] e = '0, input string n = "");
		@(posedge ref_clk);
		sel   <= 1'b1;
		addr  <= a;
		wdata <= d;
		wr    <= do_wr;
		if (do_wr)
		begin
			@(posedge ref_clk);
			wr <= 1'b0;
		end
		@(posedge ref_clk);
		sel <= 1'b0;
		#1;
		if (n != "")
		begin
			cmp_reg(n, e, rdata);
			cmp_reg("inert_rdata", 16'h0, rdata2);
		end
	endtask

	task automatic pick_write();
		seed = rnd(seed);
		w = 32 + seed % (MW - 31);
		seed = rnd(seed);
		h = 32 + seed % (MH - 31);
		xfer(ADDR_WIDTH, 16'(w), 1, 16'(w), "frame_width");
		xfer(ADDR_HEIGHT, 16'(h), 1, 16'(h), "frame_height");
		for (int i = 0; i < 3; i++)
		begin
			seed = rnd(seed);
			u[i] = seed[7:0];
			xfer(ADDR_UNI_FIRST + 3'(i), seed, 1, {8'h0, u[i]}, "uniform");
		end
	endtask

	// control packet, then the uniform image inside a black border
	task automatic add_frame();
		logic [15:0] v [0:1];
		v[0] = 16'(w);
		v[1] = 16'(h);
		exp_q.push_back({3'b110, 24'h00000f});
		for (int i = 0; i < 8; i++)
			exp_q.push_back({3'b100, 20'h0, v[i / 4][15 - 4 * (i % 4) -: 4]});
		exp_q.push_back({3'b101, 24'h0});
		exp_q.push_back({3'b110, 24'h0});
		for (int y = 0; y < h; y++)
			for (int x = 0; x < w; x++)
				exp_q.push_back({2'b00, y == h - 1 && x == w - 1,
					(x == 0 || y == 0 || x == w - 1 || y == h - 1)
					? 24'h101010 : {u[2], u[1], u[0]}});
	endtask

	always @(posedge ref_clk)
	begin
		if (resetn && valid && ready)
		begin
			if (exp_q.size() == 0)
				cmp_beat('1, {1'b0, sop, eop, data});
			else
				cmp_beat(exp_q.pop_front(), {1'b0, sop, eop, data});
		end
	end

	always @(posedge ref_clk)
	begin
		if (resetn && valid2 && ready)
		begin
			cmp_beat(bar_beat(beat2), {1'b0, sop2, eop2, data2});
			beat2 <= (beat2 == 3082) ? 0 : beat2 + 1;
		end
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == CEIL)
		begin
			mismatches++;
			final_report();
		end
	end

	initial
	begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		xfer(ADDR_RUN_CTRL, 16'h0, 0, 16'h0, "run_control");
		xfer(ADDR_RUN_STATUS, 16'h0, 0, 16'h0, "run_status");
		xfer(ADDR_WIDTH, 16'h0, 0, 16'(MW), "frame_width");
		xfer(ADDR_HEIGHT, 16'h0, 0, 16'(MH), "frame_height");
		for (int i = 0; i < 3; i++)
			xfer(ADDR_UNI_FIRST + 3'(i), 16'h0, 0, 16'h0080, "uniform");
		xfer(3'h7, 16'hffff, 1, 16'h0, "unmapped");
		xfer(ADDR_RUN_STATUS, 16'hffff, 1, 16'h0, "run_status");
		@(posedge ref_clk);
		wr    <= 1'b1;
		addr  <= ADDR_WIDTH;
		wdata <= 16'h0021;
		@(posedge ref_clk);
		wr <= 1'b0;
		xfer(ADDR_WIDTH, 16'h0, 0, 16'(MW), "frame_width");
		xfer(ADDR_RUN_CTRL, 16'hfffe, 1, 16'h0, "run_control");
		pick_write();
		for (int k = 1; k <= 2; k++)
		begin
			slow <= (k == 2);
			repeat (k) add_frame();
			len = exp_q.size() / k;
			xfer(ADDR_RUN_CTRL, 16'hffff, 1, 16'h1, "run_control");
			while (exp_q.size() > len / 2)
				@(posedge ref_clk);
			xfer(ADDR_RUN_STATUS, 16'h0, 0, 16'h1, "run_status");
			pick_write();
			xfer(ADDR_RUN_CTRL, 16'h0, 1, 16'h0, "run_control");
			while (exp_q.size() != 0)
				@(posedge ref_clk);
			repeat (40) @(posedge ref_clk);
			xfer(ADDR_RUN_STATUS, 16'h0, 0, 16'h0, "run_status");
		end
		final_report();
	end
endmodule // video_test_pattern_source_tb
